//--- core/tpm_pkg.sv
// Package for the test point multiplexers: register map, field layout,
// reset values and probe select codes.
// Assumes nothing of its surroundings; the multiplexer and the top import it whole.
package tpm_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------

    // Probe source select register (bits 3-0 pick the receiver probe).
    localparam logic [7:0] TPM_ADDR_PROBE_SOURCE_SELECT = 8'h38;
    // Read-only mirror of the receiver probe word now being presented.
    localparam logic [7:0] TPM_ADDR_PROBE_VALUE = 8'h39;
    // Reset value of the probe source select register.
    localparam logic [7:0] TPM_RST_PROBE_SOURCE_SELECT = 8'h00;
    // Value read back from an unmapped address.
    localparam logic [7:0] TPM_RD_UNMAPPED = 8'h00;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------

    // Least and most significant bit of the receiver select field.
    localparam int TPM_SEL_LSB = 0;
    localparam int TPM_SEL_MSB = 3;
    // Number of low address lines that pick the transmit probe.
    localparam int TPM_TX_SEL_BITS = 2;

    // ------------------------------------------------------------------
    // Select codes
    // ------------------------------------------------------------------

    // Transmit probe sources keyed by the two low address lines.
    localparam logic [1:0] TPM_TX_UNSPREAD_INPHASE_SYMBOL = 2'h0;
    localparam logic [1:0] TPM_TX_UNSPREAD_QUAD_SYMBOL = 2'h1;
    localparam logic [1:0] TPM_TX_CODE = 2'h2;

    // Receiver probe sources keyed by the select field.
    typedef enum logic [3:0] {
        TPM_RX_MF_INPUTS = 4'h0,
        TPM_RX_PEAK_MAG = 4'h1,
        TPM_RX_NCO_COS = 4'h2,
        TPM_RX_NCO_SIN = 4'h3,
        TPM_RX_DC_I = 4'h4,
        TPM_RX_DC_Q = 4'h5,
        TPM_RX_SUM_I = 4'h6,
        TPM_RX_SUM_Q = 4'h7,
        TPM_RX_MAG = 4'h8,
        TPM_RX_VIEW_I = 4'h9,
        TPM_RX_VIEW_Q = 4'ha,
        TPM_RX_PEAK_I = 4'hb,
        TPM_RX_PEAK_Q = 4'hc,
        TPM_RX_DOT = 4'hd,
        TPM_RX_CROSS = 4'he,
        TPM_RX_LOOPBACK = 4'hf
    } tpm_rx_sel_t;

endpackage

//--- core/tpm_rx_src_if.sv
// Interface carrying the receiver probe sources and the chosen select
// from the top module to the receiver probe multiplexer.
// Assumes all signals are produced on core_clk.
`timescale 1ns/10ps
interface tpm_rx_src_if;
    logic [2:0] mf_inphase_input;           // Matched filter I input.
    logic [2:0] mf_quad_input;              // Matched filter Q input.
    logic [9:0] mf_peak_magnitude;          // Peak magnitude, unsigned.
    logic [7:0] nco_in_phase_wave;          // NCO cosine.
    logic [7:0] nco_quadrature_wave;        // NCO sine.
    logic [16:0] downconv_inphase_result;   // Downconverter I.
    logic [16:0] downconv_quad_result;      // Downconverter Q.
    logic [9:0] mf_inphase_total;           // Matched filter I sum.
    logic [9:0] mf_quad_total;              // Matched filter Q sum.
    logic [9:0] mf_magnitude;               // Magnitude, unsigned.
    logic [7:0] mf_view_inphase;            // Viewport I.
    logic [7:0] mf_view_quad;               // Viewport Q.
    logic [7:0] mf_peak_inphase;            // Peak I.
    logic [7:0] mf_peak_quad;               // Peak Q.
    logic [16:0] demod_dot;                 // Dot product.
    logic [16:0] demod_cross;               // Cross product.
    logic [7:0] loopback_probe_word;        // Transmit loopback word.
    logic [3:0] select;                     // Receiver select field.

    // The top drives everything; the multiplexer only reads.
    modport source (
        output mf_inphase_input, mf_quad_input, mf_peak_magnitude, nco_in_phase_wave,
        nco_quadrature_wave, downconv_inphase_result, downconv_quad_result, mf_inphase_total,
        mf_quad_total, mf_magnitude, mf_view_inphase, mf_view_quad, mf_peak_inphase,
        mf_peak_quad, demod_dot, demod_cross, loopback_probe_word, select
    );
    modport sink (
        input mf_inphase_input, mf_quad_input, mf_peak_magnitude, nco_in_phase_wave,
        nco_quadrature_wave, downconv_inphase_result, downconv_quad_result, mf_inphase_total,
        mf_quad_total, mf_magnitude, mf_view_inphase, mf_view_quad, mf_peak_inphase,
        mf_peak_quad, demod_dot, demod_cross, loopback_probe_word, select
    );
endinterface

//--- core/tpm_rx_mux.sv
// Receiver probe multiplexer: picks one of sixteen receiver words and
// registers it.
// Assumes sources and select are synchronous to core_clk.
`timescale 1ns/10ps
module tpm_rx_mux
    import tpm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    tpm_rx_src_if.sink src,
    output logic [7:0] probe
);

    // ------------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------------

    logic [7:0] next_probe; // Word to present after the next edge.

    // Pick the source; each slice keeps the sign bit on bit 7 so signed
    // words stay two's complement and magnitudes stay unsigned.
    always_comb begin
        case (tpm_rx_sel_t'(src.select))
            TPM_RX_MF_INPUTS: begin
                next_probe = {2'h0, src.mf_quad_input, src.mf_inphase_input};
                next_probe[7:4] = {src.mf_quad_input[2], src.mf_quad_input};
                next_probe[3] = src.mf_inphase_input[2];
            end
            TPM_RX_PEAK_MAG: next_probe = src.mf_peak_magnitude[9:2];
            TPM_RX_NCO_COS: next_probe = src.nco_in_phase_wave;
            TPM_RX_NCO_SIN: next_probe = src.nco_quadrature_wave;
            TPM_RX_DC_I: next_probe = src.downconv_inphase_result[16:9];
            TPM_RX_DC_Q: next_probe = src.downconv_quad_result[16:9];
            TPM_RX_SUM_I: next_probe = src.mf_inphase_total[9:2];
            TPM_RX_SUM_Q: next_probe = src.mf_quad_total[9:2];
            TPM_RX_MAG: next_probe = src.mf_magnitude[9:2];
            TPM_RX_VIEW_I: next_probe = src.mf_view_inphase;
            TPM_RX_VIEW_Q: next_probe = src.mf_view_quad;
            TPM_RX_PEAK_I: next_probe = src.mf_peak_inphase;
            TPM_RX_PEAK_Q: next_probe = src.mf_peak_quad;
            TPM_RX_DOT: next_probe = src.demod_dot[16:9];
            TPM_RX_CROSS: next_probe = src.demod_cross[16:9];
            TPM_RX_LOOPBACK: next_probe = src.loopback_probe_word;
            default: next_probe = 8'h00;
        endcase
    end

    // Register the word so the probe bus never shows a decode glitch.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            probe <= 8'h00;
        end else begin
            probe <= next_probe;
        end
    end

endmodule // tpm_rx_mux

//--- core/tpm_top.sv
// Test point multiplexers: a one-bit transmit probe picked by the low
// address lines and an eight-bit receiver probe bus picked by a register.
// Assumes the probe sources come from logic on core_clk, the transmit
// and receive IF clocks being core_clk itself, and that the probe drive
// enable arrives from a pin.
//
// Summary of operation
// - Address 0,1,2 show I, Q, code.
// - Only two low address lines pick it.
// - Transmit probe always driven, three sources only.
// - Select field 38h[3:0]; 0 shows MF inputs.
// - Codes 4,5 show downconverter bits 16-9.
// - Codes 6,7 show MF sums bits 9-2.
// - Codes 8,1 show magnitudes, unsigned.
// - Codes 9,A show viewport bits 7-0.
// - Codes B,C show peak I, Q.
// - Codes D,E products; F loopback word.
// - Non-magnitude probes are two's complement.
// - Probe bus three-state, enabled by input.
// - Receiver disable clears select to zero.
`timescale 1ns/10ps
module tpm_top
    import tpm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Receiver enable; low runs the receiver reset sequence.
    input wire logic rx_enable,
    // Pin enabling the receiver probe drivers.
    input wire logic probe_drive_enable,
    // Transmitter sources.
    input wire logic unspread_inphase_symbol,
    input wire logic unspread_quad_symbol,
    input wire logic spreading_sequence_bit,
    // Receiver sources.
    input wire logic [2:0] mf_inphase_input,
    input wire logic [2:0] mf_quad_input,
    input wire logic [9:0] mf_peak_magnitude,
    input wire logic [7:0] nco_in_phase_wave,
    input wire logic [7:0] nco_quadrature_wave,
    input wire logic [16:0] downconv_inphase_result,
    input wire logic [16:0] downconv_quad_result,
    input wire logic [9:0] mf_inphase_total,
    input wire logic [9:0] mf_quad_total,
    input wire logic [9:0] mf_magnitude,
    input wire logic [7:0] mf_view_inphase,
    input wire logic [7:0] mf_view_quad,
    input wire logic [7:0] mf_peak_inphase,
    input wire logic [7:0] mf_peak_quad,
    input wire logic [16:0] demod_dot,
    input wire logic [16:0] demod_cross,
    input wire logic [7:0] loopback_probe_word,
    // Probe outputs.
    output logic tx_probe_out,
    output logic [7:0] rx_probe_bus,
    output logic rx_probe_oe
);

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------

    logic oe_meta; // First stage; only the second stage reads it.
    logic oe_sync; // Synchronised drive enable.
    logic next_oe_meta;
    logic next_oe_sync;

    // Shift the pin through two stages.
    always_comb begin
        next_oe_meta = probe_drive_enable;
        next_oe_sync = oe_meta;
    end

    // Register the synchroniser stages.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            oe_meta <= 1'b0;
            oe_sync <= 1'b0;
        end else begin
            oe_meta <= next_oe_meta;
            oe_sync <= next_oe_sync;
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------

    logic [7:0] probe_source_select; // Whole byte kept; bits 3-0 act.
    logic [7:0] next_probe_source_select;
    logic [7:0] next_reg_rdata;
    logic [7:0] rx_probe_word; // Registered multiplexer output.

    // Writes store the select byte; a disabled receiver forces it to
    // zero and wins over a write in the same cycle, since the reset
    // sequence is held for as long as the receiver stays off.
    always_comb begin
        next_probe_source_select = probe_source_select;
        if (!rx_enable) begin
            next_probe_source_select = TPM_RST_PROBE_SOURCE_SELECT;
        end else if (reg_wr && reg_addr == TPM_ADDR_PROBE_SOURCE_SELECT) begin
            next_probe_source_select = reg_wdata;
        end
    end

    // Read data stand one cycle after the read strobe and only then.
    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                TPM_ADDR_PROBE_SOURCE_SELECT: next_reg_rdata = probe_source_select;
                TPM_ADDR_PROBE_VALUE: next_reg_rdata = rx_probe_word;
                default: next_reg_rdata = TPM_RD_UNMAPPED;
            endcase
        end
    end

    // Register the select byte and the read data.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            probe_source_select <= TPM_RST_PROBE_SOURCE_SELECT;
            reg_rdata <= 8'h00;
        end else begin
            probe_source_select <= next_probe_source_select;
            reg_rdata <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Transmit probe
    // ------------------------------------------------------------------

    logic next_tx_probe_out;

    // Only the two low address lines matter and nothing gates the pin.
    // Code 3 has no source and shows zero.
    always_comb begin
        case (reg_addr[TPM_TX_SEL_BITS-1:0])
            TPM_TX_UNSPREAD_INPHASE_SYMBOL: next_tx_probe_out = unspread_inphase_symbol;
            TPM_TX_UNSPREAD_QUAD_SYMBOL: next_tx_probe_out = unspread_quad_symbol;
            TPM_TX_CODE: next_tx_probe_out = spreading_sequence_bit;
            default: next_tx_probe_out = 1'b0;
        endcase
    end

    // Register the transmit probe every edge.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_probe_out <= 1'b0;
        end else begin
            tx_probe_out <= next_tx_probe_out;
        end
    end

    // ------------------------------------------------------------------
    // Receiver probe
    // ------------------------------------------------------------------

    tpm_rx_src_if rx_src ();

    // Bundle the receiver sources for the multiplexer.
    assign rx_src.mf_inphase_input = mf_inphase_input;
    assign rx_src.mf_quad_input = mf_quad_input;
    assign rx_src.mf_peak_magnitude = mf_peak_magnitude;
    assign rx_src.nco_in_phase_wave = nco_in_phase_wave;
    assign rx_src.nco_quadrature_wave = nco_quadrature_wave;
    assign rx_src.downconv_inphase_result = downconv_inphase_result;
    assign rx_src.downconv_quad_result = downconv_quad_result;
    assign rx_src.mf_inphase_total = mf_inphase_total;
    assign rx_src.mf_quad_total = mf_quad_total;
    assign rx_src.mf_magnitude = mf_magnitude;
    assign rx_src.mf_view_inphase = mf_view_inphase;
    assign rx_src.mf_view_quad = mf_view_quad;
    assign rx_src.mf_peak_inphase = mf_peak_inphase;
    assign rx_src.mf_peak_quad = mf_peak_quad;
    assign rx_src.demod_dot = demod_dot;
    assign rx_src.demod_cross = demod_cross;
    assign rx_src.loopback_probe_word = loopback_probe_word;
    assign rx_src.select = probe_source_select[TPM_SEL_MSB:TPM_SEL_LSB];

    // Registered sixteen-way selection.
    tpm_rx_mux u_rx_mux (
        .core_clk(core_clk),
        .rst(rst),
        .src(rx_src),
        .probe(rx_probe_word)
    );

    logic [7:0] next_rx_probe_bus;
    logic next_rx_probe_oe;

    // The bus value and its driver enable come from flip-flops; the
    // pad resolves the three-state level from the enable.
    always_comb begin
        next_rx_probe_bus = rx_probe_word;
        next_rx_probe_oe = oe_sync;
    end

    // Register the receiver probe pins.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_probe_bus <= 8'h00;
            rx_probe_oe <= 1'b0;
        end else begin
            rx_probe_bus <= next_rx_probe_bus;
            rx_probe_oe <= next_rx_probe_oe;
        end
    end

endmodule // tpm_top

//--- verif/tpm_top_sva.sv
// Checker for the test point multiplexers, watching the top ports only.
// Assumes one clock, core_clk, and a synchronous active-high rst.
`timescale 1ns/10ps
module tpm_top_sva
    import tpm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic rx_enable,
    input wire logic probe_drive_enable,
    input wire logic unspread_inphase_symbol,
    input wire logic unspread_quad_symbol,
    input wire logic spreading_sequence_bit,
    input wire logic [2:0] mf_inphase_input,
    input wire logic [2:0] mf_quad_input,
    input wire logic [9:0] mf_peak_magnitude,
    input wire logic [7:0] nco_in_phase_wave,
    input wire logic [7:0] nco_quadrature_wave,
    input wire logic [16:0] downconv_inphase_result,
    input wire logic [16:0] downconv_quad_result,
    input wire logic [9:0] mf_inphase_total,
    input wire logic [9:0] mf_quad_total,
    input wire logic [9:0] mf_magnitude,
    input wire logic [7:0] mf_view_inphase,
    input wire logic [7:0] mf_view_quad,
    input wire logic [7:0] mf_peak_inphase,
    input wire logic [7:0] mf_peak_quad,
    input wire logic [16:0] demod_dot,
    input wire logic [16:0] demod_cross,
    input wire logic [7:0] loopback_probe_word,
    input wire logic tx_probe_out,
    input wire logic [7:0] rx_probe_bus,
    input wire logic rx_probe_oe
);
    // -----------------------------------------------------------------
    // Helper logic
    // -----------------------------------------------------------------
    logic [3:0] sel_q, next_sel_q; // Shadow of the select field.
    logic [2:0] up, next_up; // Edges since reset, saturating at 4, so $past never reaches into reset.
    logic [7:0] exp_w; // Word the probe bus should carry for sel_q.

    // The shadow is cleared by a receiver disable, which also wins over a write.
    always_comb begin
        next_sel_q = sel_q;
        if (rst || !rx_enable) begin
            next_sel_q = 4'h0;
        end else if (reg_wr && reg_addr == TPM_ADDR_PROBE_SOURCE_SELECT) begin
            next_sel_q = reg_wdata[3:0];
        end
        next_up = rst ? 3'h0 : ((up == 3'h4) ? up : up + 3'h1);
    end

    always_ff @(posedge core_clk) begin
        sel_q <= next_sel_q;
        up <= next_up;
    end

    // Expected word, built from the source table rather than the design.
    always_comb begin
        case (sel_q)
            4'h0: exp_w = {mf_quad_input[2], mf_quad_input, mf_inphase_input[2], mf_inphase_input};
            4'h1: exp_w = mf_peak_magnitude[9:2];
            4'h2: exp_w = nco_in_phase_wave;
            4'h3: exp_w = nco_quadrature_wave;
            4'h4: exp_w = downconv_inphase_result[16:9];
            4'h5: exp_w = downconv_quad_result[16:9];
            4'h6: exp_w = mf_inphase_total[9:2];
            4'h7: exp_w = mf_quad_total[9:2];
            4'h8: exp_w = mf_magnitude[9:2];
            4'h9: exp_w = mf_view_inphase;
            4'ha: exp_w = mf_view_quad;
            4'hb: exp_w = mf_peak_inphase;
            4'hc: exp_w = mf_peak_quad;
            4'hd: exp_w = demod_dot[16:9];
            4'he: exp_w = demod_cross[16:9];
            default: exp_w = loopback_probe_word;
        endcase
    end

    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_read_sel;
        reg_rd && reg_addr == TPM_ADDR_PROBE_SOURCE_SELECT;
    endsequence

    property p_rx_group(logic [3:0] lo, logic [3:0] hi);
        up == 3'h4 && $past(sel_q, 2) >= lo && $past(sel_q, 2) <= hi |-> rx_probe_bus == $past(exp_w, 2);
    endproperty

    a_tx_inphase_pick: assert property (up != 3'h0 && reg_addr[1:0] == TPM_TX_UNSPREAD_INPHASE_SYMBOL
        |=> tx_probe_out == $past(unspread_inphase_symbol)) else $error("tx probe not showing I symbol");
    a_tx_quad_pick: assert property (up != 3'h0 && reg_addr[1:0] == TPM_TX_UNSPREAD_QUAD_SYMBOL
        |=> tx_probe_out == $past(unspread_quad_symbol)) else $error("tx probe not showing Q symbol");
    a_tx_code_pick: assert property (up != 3'h0 && reg_addr[1:0] == TPM_TX_CODE
        |=> tx_probe_out == $past(spreading_sequence_bit)) else $error("tx probe not showing code");
    a_tx_spare_low: assert property (up != 3'h0 && reg_addr[1:0] == 2'h3
        |=> !tx_probe_out) else $error("tx probe shows a fourth source");
    a_rx_mf_inputs: assert property (p_rx_group(4'h0, 4'h0)) else $error("rx probe wrong for code 0");
    a_rx_peak_mag: assert property (p_rx_group(4'h1, 4'h1)) else $error("rx probe wrong for code 1");
    a_rx_nco_pair: assert property (p_rx_group(4'h2, 4'h3)) else $error("rx probe wrong for nco");
    a_rx_dc_slice: assert property (p_rx_group(4'h4, 4'h5)) else $error("rx probe wrong for downconv");
    a_rx_sum_mag: assert property (p_rx_group(4'h6, 4'h8)) else $error("rx probe wrong for sums");
    a_rx_view_peak: assert property (p_rx_group(4'h9, 4'hc)) else $error("rx probe wrong for view");
    a_rx_prod_loop: assert property (p_rx_group(4'hd, 4'hf)) else $error("rx probe wrong for products");
    a_oe_follows_pin: assert property (up == 3'h4
        |-> rx_probe_oe == $past(probe_drive_enable, 3)) else $error("probe drive enable not followed");
    a_rd_select_back: assert property (s_read_sel
        |=> reg_rdata[3:0] == $past(sel_q)) else $error("select field read back wrong");
endmodule // tpm_top_sva

bind tpm_top tpm_top_sva tpm_top_sva_i (.*);

//--- verif/tpm_probe_observer.sv
// Observer at the receiver probe pins, standing in for test equipment.
// Assumes bus and enable change only on core_clk; the pins float when off.
`timescale 1ns/10ps
module tpm_probe_observer (
    input wire logic core_clk,
    input wire logic [7:0] rx_probe_bus,
    input wire logic rx_probe_oe,
    output logic [7:0] pin_level
);
    logic [7:0] last, next_last; // Last value actually driven on the pins.

    // Remember what was driven so an undriven bus can show its inverse.
    always_comb begin
        next_last = rx_probe_oe ? rx_probe_bus : last;
    end

    always_ff @(posedge core_clk) begin
        last <= next_last;
    end

    // No pull on these pins, so a released bus must not look like stale data.
    assign pin_level = rx_probe_oe ? rx_probe_bus : ~last;
endmodule // tpm_probe_observer

//--- verif/tpm_top_tb.sv
// Self-checking bench for the test point multiplexers.
// Assumes the design and its checker are compiled alongside.
`timescale 1ns/10ps
module tpm_top_tb;
    import tpm_pkg::*;
    typedef struct packed {logic [3:0] sel; logic [7:0] word;} tpm_row_t;
    localparam tpm_row_t ROWS [16] = '{'{4'h0, 8'hd3}, '{4'h1, 8'he1}, '{4'h2, 8'h5a}, '{4'h3, 8'ha5},
        '{4'h4, 8'h3c}, '{4'h5, 8'hc3}, '{4'h6, 8'h81}, '{4'h7, 8'h7e}, '{4'h8, 8'hf0}, '{4'h9, 8'h12},
        '{4'ha, 8'h34}, '{4'hb, 8'h56}, '{4'hc, 8'h78}, '{4'hd, 8'h9a}, '{4'he, 8'hbc}, '{4'hf, 8'hde}};
    logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rx_enable = 1'b1;
    logic probe_drive_enable = 1'b0, tx_probe_out, rx_probe_oe;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rx_probe_bus, pin_level, rd;
    logic unspread_inphase_symbol = 1'b0, unspread_quad_symbol = 1'b0, spreading_sequence_bit = 1'b0;
    logic [2:0] mf_inphase_input = 3'h3, mf_quad_input = 3'h5;
    // Junk below each slice catches a slice taken at the wrong bits.
    logic [9:0] mf_peak_magnitude = {8'he1, 2'h3}, mf_inphase_total = {8'h81, 2'h2};
    logic [9:0] mf_quad_total = {8'h7e, 2'h1}, mf_magnitude = {8'hf0, 2'h3};
    logic [7:0] nco_in_phase_wave = 8'h5a, nco_quadrature_wave = 8'ha5, mf_view_inphase = 8'h12;
    logic [7:0] mf_view_quad = 8'h34, mf_peak_inphase = 8'h56, mf_peak_quad = 8'h78, loopback_probe_word = 8'hde;
    logic [16:0] downconv_inphase_result = {8'h3c, 9'h1ff}, downconv_quad_result = {8'hc3, 9'h000};
    logic [16:0] demod_dot = {8'h9a, 9'h155}, demod_cross = {8'hbc, 9'h0aa};
    int mismatches = 0, tests_run = 0;

    tpm_top tpm_top_i (.*);
    tpm_probe_observer tpm_probe_observer_i (.core_clk, .rx_probe_bus, .rx_probe_oe, .pin_level);

    always #2.5 core_clk = ~core_clk;

    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Waits n edges and then lets their updates land.
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the read edge.
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask

    // A hang is cut short here and counted as a failure.
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        wrap_up();
    end

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        settle(4);
        reg_read(TPM_ADDR_PROBE_SOURCE_SELECT, rd);
        check("select after reset", rd, TPM_RST_PROBE_SOURCE_SELECT);
        check("probe after reset", rx_probe_bus, 8'hd3);
        foreach (ROWS[k]) begin
            reg_write(TPM_ADDR_PROBE_SOURCE_SELECT, {4'h0, ROWS[k].sel});
            settle(2);
            check("rx probe word", rx_probe_bus, ROWS[k].word);
            reg_read(TPM_ADDR_PROBE_VALUE, rd);
            check("probe mirror", rd, ROWS[k].word);
            // Read data must drop back to zero once their cycle is over.
            settle(1);
            check("read data cleared", reg_rdata, 8'h00);
        end
        // A source change needs two edges to reach the pins.
        reg_write(TPM_ADDR_PROBE_SOURCE_SELECT, 8'h02);
        repeat (3) @(posedge core_clk);
        nco_in_phase_wave <= 8'h11;
        settle(1);
        check("probe one edge on", rx_probe_bus, 8'h5a);
        settle(1);
        check("probe two edges on", rx_probe_bus, 8'h11);
        // High address bits toggle too; only the low two may matter.
        for (int a = 0; a < 4; a++) begin
            for (int p = 0; p < 2; p++) begin
                @(posedge core_clk);
                reg_addr <= {6'(6'h3f ^ (a * 5 + p)), 2'(a)};
                {unspread_inphase_symbol, unspread_quad_symbol, spreading_sequence_bit} <= p ? 3'b101 : 3'b010;
                settle(1);
                check("tx probe", {7'h00, tx_probe_out}, {7'h00, 1'((p ? 4'b0101 : 4'b0010) >> a)});
            end
        end
        // Disabling the receiver clears the select and blocks writes.
        @(posedge core_clk);
        rx_enable <= 1'b0;
        reg_write(TPM_ADDR_PROBE_SOURCE_SELECT, 8'h05);
        settle(2);
        check("probe while disabled", rx_probe_bus, 8'hd3);
        @(posedge core_clk);
        rx_enable <= 1'b1;
        reg_write(TPM_ADDR_PROBE_VALUE, 8'h0f);
        reg_read(TPM_ADDR_PROBE_SOURCE_SELECT, rd);
        check("select after enable", rd, 8'h00);
        reg_read(8'h10, rd);
        check("unmapped read", rd, TPM_RD_UNMAPPED);
        // Probe drivers follow the enable pin three edges late.
        check("drive off", {7'h00, rx_probe_oe}, 8'h00);
        @(posedge core_clk);
        probe_drive_enable <= 1'b1;
        settle(2);
        check("drive still off", {7'h00, rx_probe_oe}, 8'h00);
        settle(1);
        check("drive on", {7'h00, rx_probe_oe}, 8'h01);
        check("pins driven", pin_level, 8'hd3);
        // Dropping the pin releases the bus three edges later.
        @(posedge core_clk);
        probe_drive_enable <= 1'b0;
        settle(3);
        check("drive off again", {7'h00, rx_probe_oe}, 8'h00);
        check("pins released", pin_level, 8'h2c);
        wrap_up();
    end
endmodule // tpm_top_tb
